/* File: src/video_clock_sync_outputs.sv */
// Output clocks, composite data bus and sync outputs of the video digitizer
// Overview of operation
// - Select high picks internal clock, else external
// - Output double-rate line-locked pixel clock
// - Transfer clock runs at half rate
// - One 8-bit word per two fast cycles
// - Sync interval carries field, frequency, phase
// - Accept 20 MHz synthesizer reference clock
// - Drive inverted synthesizer reference clock
// - Locked: low line pulse after input fall
// - Locked: line falls follow the input line falls
// - No video, below 4Ah: even pulses
// - No video, above 88h: skip eighth
// - 4Ah..88h: eighth pulse shrinks per step
// - Locked: field sync falls on vsync start
// - No video: field sync held high
// - PAL burst flag valid with odd field
module video_clock_sync_outputs (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        pixel_clock_source_select,
  input  wire logic        internal_double_rate_clock,
  input  wire logic        external_double_rate_clock_in,
  input  wire logic        ref_clock_in,
  input  wire logic        video_present,
  input  wire logic        locked,
  input  wire logic        pal_mode,
  input  wire logic        line_sync_in_n,
  input  wire logic        field_sync_in_n,
  input  wire logic        odd_field,
  input  wire logic        burst_on_line_310,
  input  wire logic [7:0]  video_sample,
  input  wire logic [7:0]  subcarrier_freq,
  input  wire logic [7:0]  subcarrier_phase,
  input  wire logic [7:0]  phase_error_setting,
  input  wire logic [11:0] free_run_line_period,
  output logic             double_rate_pixel_clock,
  output logic             half_rate_transfer_clock,
  output logic             direct_synthesizer_clock,
  output logic             ref_clock_inv_out,
  output logic [7:0]       composite_video_bus,
  output logic [1:0]       field_identifier,
  output logic             line_sync_out,
  output logic             field_sync_out
);
  typedef struct packed {
    // Clock path
    logic       sel_clk;
    logic       sel_clk_d1;
    logic       half;
    logic       ref_clk;
    logic       ref_inv;
    // Bus path
    logic [7:0] bus;
    logic [1:0] fid;
    // Sync path
    logic       hs_in_d1;
    logic       vs_in_d1;
    logic       in_sync;
    logic       hs_out;
    logic       vs_out;
    logic       vs_seen;
    logic [7:0] hs_cnt;
    video_sync_pkg::aux_sel_t aux;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   fast_rise;
  logic   free_hs_n;

  // Falling edge of an active-low input against its registered copy
  function automatic logic fell_edge(input logic prev, input logic now);
    fell_edge = prev && !now;
  endfunction : fell_edge

  // Word shown on the bus for each slot of the sync interval
  function automatic logic [7:0] aux_word(
    input video_sync_pkg::aux_sel_t sel,
    input logic [1:0]               fid,
    input logic [7:0]               freq,
    input logic [7:0]               phase,
    input logic [7:0]               sample
  );
    unique case (sel)
      video_sync_pkg::AUX_FIELD: aux_word = {6'h00, fid};
      video_sync_pkg::AUX_FREQ:  aux_word = freq;
      video_sync_pkg::AUX_PHASE: aux_word = phase;
      video_sync_pkg::AUX_VIDEO: aux_word = sample;
    endcase
  endfunction : aux_word

  // Selector for the double-rate clock source
  function automatic logic pick_clock(input logic sel, input logic int_clk, input logic ext_clk);
    if (sel) begin
      pick_clock = int_clk;
    end else begin
      pick_clock = ext_clk;
    end
  endfunction : pick_clock

  // Rising edge of the selected double-rate clock as seen on clk_sys
  assign fast_rise = s_q.sel_clk && !s_q.sel_clk_d1;

  // Free-running line sync used whenever lock is lost
  line_sync_free_run u_free_run (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .tick                (fast_rise),
    .line_period         (free_run_line_period),
    .pulse_width         (video_sync_pkg::HSYNC_WIDTH_DEFAULT),
    .phase_error_setting (phase_error_setting),
    .sync_n              (free_hs_n)
  );

  // Next state for the whole block
  always_comb begin
    logic hs_fall;
    logic vs_fall;
    hs_fall = 1'b0;
    vs_fall = 1'b0;
    s_d     = s_q;
    // Clock path: selected double-rate clock and reference copies
    s_d.sel_clk    = pick_clock(pixel_clock_source_select, internal_double_rate_clock,
                                external_double_rate_clock_in);
    s_d.sel_clk_d1 = s_q.sel_clk;
    s_d.ref_clk    = ref_clock_in;
    s_d.ref_inv    = !ref_clock_in;
    s_d.hs_in_d1   = line_sync_in_n;
    s_d.vs_in_d1   = field_sync_in_n;
    // Input sync edges against last cycle's level
    hs_fall = fell_edge(s_q.hs_in_d1, line_sync_in_n);
    vs_fall = fell_edge(s_q.vs_in_d1, field_sync_in_n);
    s_d.in_sync = !line_sync_in_n;

    // Data path: one word per two double-rate rises
    if (fast_rise) begin
      s_d.half = !s_q.half;
      // New word on the falling half so it is stable at the next rising edge
      if (s_q.half) begin
        if (s_q.in_sync && s_q.aux != video_sync_pkg::AUX_VIDEO) begin
          s_d.bus = aux_word(s_q.aux, s_q.fid, subcarrier_freq, subcarrier_phase, video_sample);
          s_d.aux = video_sync_pkg::aux_sel_t'(s_q.aux + 2'h1);
        end else begin
          s_d.bus = s_q.in_sync ? video_sync_pkg::CVBS_RESET : video_sample;
        end
      end
    end
    // Slot counter restarts whenever the sync interval ends
    if (!s_q.in_sync) begin
      s_d.aux = video_sync_pkg::AUX_FIELD;
    end

    // Field status word
    s_d.fid[0] = odd_field;
    s_d.fid[1] = pal_mode && odd_field && burst_on_line_310;

    // Sync outputs follow the input while locked, else line sync free-runs and field sync stays high
    if (video_present && locked) begin
      // Pulse width counts double-rate rises so line spacing tracks the input
      if (hs_fall) begin
        s_d.hs_out = 1'b0;
        s_d.hs_cnt = video_sync_pkg::HSYNC_WIDTH_DEFAULT;
      end else if (fast_rise && s_q.hs_cnt != 8'h00) begin
        s_d.hs_cnt = s_q.hs_cnt - 8'h01;
        s_d.hs_out = (s_q.hs_cnt == 8'h01);
      end
      // Only the first field sync fall of a blanking interval counts
      if (vs_fall && !s_q.vs_seen) begin
        s_d.vs_out  = 1'b0;
        s_d.vs_seen = 1'b1;
      end else if (field_sync_in_n && line_sync_in_n && s_q.vs_seen) begin
        s_d.vs_out  = 1'b1;
        s_d.vs_seen = 1'b0;
      end
    end else begin
      s_d.hs_out  = free_hs_n;
      s_d.hs_cnt  = 8'h00;
      s_d.vs_out  = 1'b1;
      s_d.vs_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      // Reset holds both syncs high and the bus at zero
      s_q <= '{
        sel_clk:    1'b0,
        sel_clk_d1: 1'b0,
        half:       1'b0,
        ref_clk:    1'b0,
        ref_inv:    1'b1,
        bus:        video_sync_pkg::CVBS_RESET,
        fid:        2'b00,
        hs_in_d1:   1'b1,
        vs_in_d1:   1'b1,
        in_sync:    1'b0,
        hs_out:     1'b1,
        vs_out:     1'b1,
        vs_seen:    1'b0,
        hs_cnt:     8'h00,
        aux:        video_sync_pkg::AUX_FIELD
      };
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a register bit
  assign double_rate_pixel_clock  = s_q.sel_clk;
  assign half_rate_transfer_clock = s_q.half;
  assign direct_synthesizer_clock = s_q.ref_clk;
  assign ref_clock_inv_out        = s_q.ref_inv;
  assign composite_video_bus      = s_q.bus;
  assign field_identifier         = s_q.fid;
  assign line_sync_out            = s_q.hs_out;
  assign field_sync_out           = s_q.vs_out;
endmodule : video_clock_sync_outputs

/* File: src/video_sync_pkg.sv */
// Shared constants and types for the video clock and sync output block
package video_sync_pkg;
  localparam int unsigned CLK_SYS_MHZ          = 100;
  localparam int unsigned REF_CLK_MHZ          = 20;
  localparam logic [7:0]  FREE_RUN_EVEN_LIMIT  = 8'h4A;
  localparam logic [7:0]  SKIP_LIMIT           = 8'h88;
  localparam logic [7:0]  SHRINK_BASE          = 8'h49;
  localparam logic [7:0]  SHRINK_GONE          = 8'h89;
  localparam logic [2:0]  SKIP_SLOT            = 3'h7;
  localparam logic [11:0] LINE_PERIOD_DEFAULT  = 12'h06B4;
  localparam logic [7:0]  HSYNC_WIDTH_DEFAULT  = 8'h40;
  localparam logic [7:0]  CVBS_RESET           = 8'h00;
  localparam int unsigned AUX_WORDS            = 4;

  typedef enum logic [1:0] {
    AUX_FIELD,
    AUX_FREQ,
    AUX_PHASE,
    AUX_VIDEO
  } aux_sel_t;
endpackage : video_sync_pkg

/* File: src/line_sync_free_run.sv */
// Free-running line sync generator with lead/lag pulse shrinking
module line_sync_free_run (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        tick,
  input  wire logic [11:0] line_period,
  input  wire logic [7:0]  pulse_width,
  input  wire logic [7:0]  phase_error_setting,
  output logic             sync_n
);
  typedef struct packed {
    logic [11:0] cnt;
    logic [2:0]  line;
    logic        sync_n;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Width of the eighth pulse for the current setting
  function automatic logic [7:0] eighth_width(input logic [7:0] w, input logic [7:0] ll);
    logic [7:0] steps;
    steps = 8'h00;
    if (ll > video_sync_pkg::SHRINK_BASE) begin
      steps = ll - video_sync_pkg::SHRINK_BASE;
    end
    if (ll >= video_sync_pkg::SHRINK_GONE || steps >= w) begin
      eighth_width = 8'h00;
    end else begin
      eighth_width = w - steps;
    end
  endfunction : eighth_width

  always_comb begin
    logic [7:0] w;
    w   = 8'h00;
    s_d = s_q;
    if (tick) begin
      if (s_q.cnt >= line_period - 12'h001) begin
        s_d.cnt  = 12'h000;
        s_d.line = s_q.line + 3'h1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h001;
      end
      w = pulse_width;
      if (s_d.line == video_sync_pkg::SKIP_SLOT) begin
        w = eighth_width(pulse_width, phase_error_setting);
      end
      s_d.sync_n = !(s_d.cnt < {4'h0, w});
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{cnt: 12'h000, line: 3'h0, sync_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_n = s_q.sync_n;
endmodule : line_sync_free_run

/* File: bench/video_word_receiver.sv */
// Downstream receiver model that latches each composite word
module video_word_receiver (
  input  wire logic       half_rate_transfer_clock,
  input  wire logic [7:0] composite_video_bus,
  output logic      [7:0] word_q,
  output logic     [15:0] word_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial word_q = 8'h00;
  initial word_cnt = 16'h0000;
  always @(posedge half_rate_transfer_clock) begin
    word_q <= composite_video_bus;
    word_cnt <= word_cnt + 16'h0001;
  end
endmodule : video_word_receiver

/* File: bench/video_sync_monitor.sv */
// Checker for clocks, composite bus and sync outputs
module video_sync_monitor (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       pixel_clock_source_select,
  input wire logic       internal_double_rate_clock,
  input wire logic       external_double_rate_clock_in,
  input wire logic       video_present,
  input wire logic       locked,
  input wire logic       pal_mode,
  input wire logic       line_sync_in_n,
  input wire logic       field_sync_in_n,
  input wire logic       odd_field,
  input wire logic       burst_on_line_310,
  input wire logic       ref_clock_in,
  input wire logic       double_rate_pixel_clock,
  input wire logic       half_rate_transfer_clock,
  input wire logic       direct_synthesizer_clock,
  input wire logic       ref_clock_inv_out,
  input wire logic [7:0] composite_video_bus,
  input wire logic [1:0] field_identifier,
  input wire logic       line_sync_out,
  input wire logic       field_sync_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_src_int: assert property (pixel_clock_source_select |=>
    double_rate_pixel_clock == $past(internal_double_rate_clock)) else $error("internal clock not passed");
  chk_src_ext: assert property (!pixel_clock_source_select |=>
    double_rate_pixel_clock == $past(external_double_rate_clock_in)) else $error("external clock not passed");
  chk_half_step: assert property ($changed(half_rate_transfer_clock) |->
    $past(double_rate_pixel_clock) && !$past(double_rate_pixel_clock, 2))
    else $error("transfer clock moved off a fast rise");
  chk_bus_word: assert property ($changed(composite_video_bus) |->
    $fell(half_rate_transfer_clock)) else $error("bus changed off the word boundary");
  chk_ref_inverse: assert property (ref_clock_inv_out != direct_synthesizer_clock)
    else $error("reference outputs not inverse");
  chk_ref_copy: assert property (1'b1 |=> direct_synthesizer_clock == $past(ref_clock_in))
    else $error("reference copy wrong");
  chk_line_pulse: assert property ($fell(line_sync_in_n) && video_present && locked |->
    ##[1:2] !line_sync_out) else $error("no line pulse after input fall");
  chk_field_fall: assert property ($fell(field_sync_in_n) && video_present && locked && field_sync_out |=>
    !field_sync_out) else $error("field sync did not fall");
  chk_field_idle: assert property (!(video_present && locked) |=> field_sync_out)
    else $error("field sync low without lock");
  chk_field_id: assert property (1'b1 |=> field_identifier[0] == $past(odd_field) &&
    field_identifier[1] == ($past(pal_mode) && $past(odd_field) && $past(burst_on_line_310)))
    else $error("field id wrong");
endmodule : video_sync_monitor
bind video_clock_sync_outputs video_sync_monitor mon (.*);

/* File: bench/video_clock_sync_outputs_bench.sv */
// Self-checking bench for the video clock and sync output block
module video_clock_sync_outputs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, pixel_clock_source_select = 1, external_double_rate_clock_in = 0;
  logic video_present = 1, locked = 0, pal_mode = 1, line_sync_in_n = 1, field_sync_in_n = 1;
  logic odd_field = 1, burst_on_line_310 = 1, ls_prev = 1;
  logic [7:0] video_sample = 8'h5A, subcarrier_freq = 8'h33, subcarrier_phase = 8'hC4, phase_error_setting = 8'h20;
  logic [11:0] free_run_line_period = 12'h0080;
  logic [1:0] div = 2'h0, field_identifier;
  logic internal_double_rate_clock, ref_clock_in, double_rate_pixel_clock, half_rate_transfer_clock;
  logic direct_synthesizer_clock, ref_clock_inv_out, line_sync_out, field_sync_out;
  logic [7:0] composite_video_bus, word_q;
  logic [15:0] word_cnt;
  int n_errors = 0, num_checks = 0, falls = 0, cycles = 0;
  video_clock_sync_outputs DUT (.*);
  video_word_receiver rx (.*);
  assign internal_double_rate_clock = div[1];
  assign ref_clock_in = div[0];
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) div <= div + 2'h1;
  always @(posedge clk_sys) begin
    ls_prev <= line_sync_out;
    if (ls_prev && !line_sync_out) falls++;
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic next_word(output logic [7:0] w);
    logic [15:0] c;
    c = word_cnt;
    repeat (40) if (word_cnt == c) @(negedge clk_sys);
    w = word_q;
  endtask : next_word
  task automatic t_select;
    int n;
    n = 0;
    pixel_clock_source_select = 0;
    repeat (3) @(negedge clk_sys);
    repeat (16) begin @(negedge clk_sys); n += double_rate_pixel_clock; end
    check("ext_clk", 0, 16'(n));
    pixel_clock_source_select = 1;
    n = 0;
    repeat (3) @(negedge clk_sys);
    repeat (16) begin @(negedge clk_sys); n += double_rate_pixel_clock; end
    check("int_clk", 8, 16'(n));
  endtask : t_select
  task automatic t_sync;
    logic [7:0] a [6];
    int hit;
    hit = 0;
    locked = 1;
    next_word(a[0]);
    next_word(a[0]);
    check("video_word", 8'h5A, a[0]);
    line_sync_in_n = 0;
    for (int i = 0; i < 6; i++) next_word(a[i]);
    for (int i = 1; i < 5; i++) if (a[i] == 8'h33 && a[i+1] == 8'hC4) hit = i;
    check("freq_phase", 1, 16'(hit != 0));
    check("field_word", 3, 16'(a[hit > 0 ? hit - 1 : 0][1:0]));
    check("line_out", 0, 16'(line_sync_out));
    line_sync_in_n = 1;
    check("fid_odd", 3, 16'(field_identifier));
    odd_field = 0;
    repeat (2) @(negedge clk_sys);
    check("fid_even", 0, 16'(field_identifier));
    repeat (300) @(negedge clk_sys);
    field_sync_in_n = 0;
    repeat (2) @(negedge clk_sys);
    check("field_out", 0, 16'(field_sync_out));
    field_sync_in_n = 1;
  endtask : t_sync
  task automatic t_free(logic [7:0] ll, int exp);
    video_present = 0;
    phase_error_setting = ll;
    repeat (520) @(negedge clk_sys);
    falls = 0;
    repeat (4096) @(negedge clk_sys);
    check("line_falls", 16'(exp), 16'(falls));
    check("field_idle", 1, 16'(field_sync_out));
  endtask : t_free
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 0;
    t_select();
    t_sync();
    t_free(8'h49, 8);
    t_free(8'h60, 8);
    t_free(8'h89, 7);
    t_free(8'hA0, 7);
    test_done();
  end
endmodule : video_clock_sync_outputs_bench
